// ---- hw/eag_extend.sv ----
// Zero and sign extension of the displacement and immediate fields.
`timescale 1ns/1ns
`default_nettype none

module eag_extend (
	// Raw fields.
	input  wire logic [3:0]  low_in,
	input  wire logic [7:0]  disp8_in,
	input  wire logic [11:0] disp12_in,
	// Extended values.
	output logic      [31:0] zext4_out,
	output logic      [31:0] zext8_out,
	output logic      [31:0] sext8_out,
	output logic      [31:0] sext12_out
);

	// ****************************************************************
	// Extension.
	// ****************************************************************
	assign zext4_out  = {28'h000_0000, low_in};
	assign zext8_out  = {24'h00_0000, disp8_in};
	assign sext8_out  = {{24{disp8_in[7]}}, disp8_in};
	assign sext12_out = {{20{disp12_in[11]}}, disp12_in};

endmodule : eag_extend
`default_nettype wire

// ---- hw/eag_fields.sv ----
// Splitter of the 16-bit instruction word into its fields.
`timescale 1ns/1ns
`default_nettype none

module eag_fields (
	// Instruction word.
	input  wire logic [15:0] instr_in,
	// Fields.
	output logic      [3:0]  opcode_out,
	output logic      [3:0]  field_n_out,
	output logic      [3:0]  field_m_out,
	output logic      [3:0]  field_low_out,
	output logic      [7:0]  disp8_out,
	output logic      [11:0] disp12_out
);

	// ****************************************************************
	// Field extraction.
	// ****************************************************************
	assign opcode_out    = instr_in[eag_pkg::EAG_OPC_MSB:eag_pkg::EAG_OPC_LSB];
	assign field_n_out   = instr_in[eag_pkg::EAG_N_MSB:eag_pkg::EAG_N_LSB];
	assign field_m_out   = instr_in[eag_pkg::EAG_M_MSB:eag_pkg::EAG_M_LSB];
	assign field_low_out = instr_in[eag_pkg::EAG_LOW_MSB:eag_pkg::EAG_LOW_LSB];
	assign disp8_out     = instr_in[eag_pkg::EAG_D8_MSB:0];
	assign disp12_out    = instr_in[eag_pkg::EAG_D12_MSB:0];

endmodule : eag_fields
`default_nettype wire

// ---- hw/eag_pkg.sv ----
// Package of constants, types and helper functions for the effective address generator.
package eag_pkg;

	// ****************************************************************
	// Operand modes selected by the instruction decoder.
	// ****************************************************************
	typedef enum logic [3:0] {
		EAG_MODE_REG_DIRECT   = 4'h0,
		EAG_MODE_REG_INDIRECT = 4'h1,
		EAG_MODE_POST_INC     = 4'h2,
		EAG_MODE_PRE_DEC      = 4'h3,
		EAG_MODE_DISP4        = 4'h4,
		EAG_MODE_INDEXED      = 4'h5,
		EAG_MODE_GBR_DISP     = 4'h6,
		EAG_MODE_PC_DISP8     = 4'h7,
		EAG_MODE_PC_DISP12    = 4'h8,
		EAG_MODE_PC_REG       = 4'h9,
		EAG_MODE_IMM_ZERO     = 4'ha,
		EAG_MODE_IMM_SIGN     = 4'hb,
		EAG_MODE_TRAP         = 4'hc,
		EAG_MODE_CTL_REG      = 4'hd,
		EAG_MODE_CTL_MEM      = 4'he,
		EAG_MODE_UNUSED       = 4'hf
	} eag_mode_t;

	// ****************************************************************
	// Access sizes.
	// ****************************************************************
	typedef enum logic [1:0] {
		EAG_SIZE_BYTE = 2'h0,
		EAG_SIZE_WORD = 2'h1,
		EAG_SIZE_LONG = 2'h2,
		EAG_SIZE_BAD  = 2'h3
	} eag_size_t;

	// ****************************************************************
	// Field positions of the 16-bit instruction word.
	// ****************************************************************
	localparam int EAG_OPC_MSB  = 15;
	localparam int EAG_OPC_LSB  = 12;
	localparam int EAG_N_MSB    = 11;
	localparam int EAG_N_LSB    = 8;
	localparam int EAG_M_MSB    = 7;
	localparam int EAG_M_LSB    = 4;
	localparam int EAG_LOW_MSB  = 3;
	localparam int EAG_LOW_LSB  = 0;
	localparam int EAG_D8_MSB   = 7;
	localparam int EAG_D12_MSB  = 11;

	// ****************************************************************
	// Step sizes, shift counts and reset values.
	// ****************************************************************
	localparam logic [31:0] EAG_STEP_BYTE  = 32'h0000_0001;
	localparam logic [31:0] EAG_STEP_WORD  = 32'h0000_0002;
	localparam logic [31:0] EAG_STEP_LONG  = 32'h0000_0004;
	localparam int          EAG_PC_SHIFT   = 1;
	localparam int          EAG_TRAP_SHIFT = 2;
	localparam logic [31:0] EAG_RST_WORD   = 32'h0000_0000;
	localparam logic [3:0]  EAG_RST_NIB    = 4'h0;
	localparam logic [3:0]  EAG_RST_MODE   = 4'h0;

	// Returns the byte count of one access of the given size.
	function automatic logic [31:0] eag_step(input eag_size_t size);
		case (size)
			EAG_SIZE_BYTE: eag_step = EAG_STEP_BYTE;
			EAG_SIZE_WORD: eag_step = EAG_STEP_WORD;
			default:       eag_step = EAG_STEP_LONG;
		endcase
	endfunction : eag_step

	// Scales a displacement by 1, 2 or 4 according to the size.
	function automatic logic [31:0] eag_scale(input logic [31:0] value, input eag_size_t size);
		case (size)
			EAG_SIZE_BYTE: eag_scale = value;
			EAG_SIZE_WORD: eag_scale = value << 1;
			default:       eag_scale = value << 2;
		endcase
	endfunction : eag_scale

endpackage : eag_pkg

// ---- hw/eag_top.sv ----
// Effective address generator with instruction field extraction.
`timescale 1ns/1ns
`default_nettype none

module eag_top (
	// Clock and reset.
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Request from the instruction decoder.
	input  wire logic        req_valid_in,
	input  wire logic [15:0] instr_in,
	input  wire logic [3:0]  mode_in,
	input  wire logic [1:0]  size_in,
	input  wire logic        sel_src_in,
	input  wire logic        branch_in,
	// Register file values for this request.
	input  wire logic [31:0] reg_value_in,
	input  wire logic [31:0] gr_zero_in,
	input  wire logic [31:0] global_base_register_in,
	input  wire logic [31:0] pc_in,
	// Result towards the memory access unit.
	output logic             done_out,
	output logic             error_out,
	output logic [3:0]       mode_out,
	output logic [31:0]      ea_out,
	output logic             mem_access_out,
	output logic [31:0]      operand_out,
	output logic             operand_valid_out,
	// Write-back of the address register.
	output logic             wb_en_out,
	output logic [3:0]       wb_index_out,
	output logic [31:0]      wb_value_out,
	// Control register load.
	output logic             ctl_load_out,
	output logic             ctl_from_mem_out,
	// Decoded fields.
	output logic [3:0]       opcode_out,
	output logic [3:0]       field_n_out,
	output logic [3:0]       field_m_out,
	output logic [3:0]       field_low_out
);

	// ****************************************************************
	// Field extraction and extension.
	// ****************************************************************
	logic [3:0]            f_opcode;
	logic [3:0]            f_n;
	logic [3:0]            f_m;
	logic [3:0]            f_low;
	logic [7:0]            f_disp8;
	logic [11:0]           f_disp12;
	logic [31:0]           x_zext4;
	logic [31:0]           x_zext8;
	logic [31:0]           x_sext8;
	logic [31:0]           x_sext12;
	eag_pkg::eag_mode_t    mode;
	eag_pkg::eag_size_t    size;
	logic [31:0]           step;

	eag_fields u_fields (
		.instr_in      (instr_in),
		.opcode_out    (f_opcode),
		.field_n_out   (f_n),
		.field_m_out   (f_m),
		.field_low_out (f_low),
		.disp8_out     (f_disp8),
		.disp12_out    (f_disp12)
	);

	eag_extend u_extend (
		.low_in     (f_low),
		.disp8_in   (f_disp8),
		.disp12_in  (f_disp12),
		.zext4_out  (x_zext4),
		.zext8_out  (x_zext8),
		.sext8_out  (x_sext8),
		.sext12_out (x_sext12)
	);

	assign mode = eag_pkg::eag_mode_t'(mode_in);
	assign size = eag_pkg::eag_size_t'(size_in);

	// Control register loads from memory always move a longword.
	assign step = (mode == eag_pkg::EAG_MODE_CTL_MEM) ? eag_pkg::EAG_STEP_LONG : eag_pkg::eag_step(size);

	// ****************************************************************
	// Shared arithmetic and refusal of the undefined size.
	// ****************************************************************
	logic [31:0] inc_value;
	logic [31:0] dec_value;
	logic [3:0]  next_wb_index;
	logic        size_refused;

	// Adds a doubled, sign-extended displacement to the program counter.
	function automatic logic [31:0] pc_target(input logic [31:0] base, input logic [31:0] disp_ext);
		pc_target = base + (disp_ext << eag_pkg::EAG_PC_SHIFT);
	endfunction : pc_target

	// Both sums keep 32 bits, so a step across the top of memory wraps.
	assign inc_value     = reg_value_in + step;
	assign dec_value     = reg_value_in - step;
	assign next_wb_index = sel_src_in ? f_m : f_n;

	// The memory modes from register indirect to GBR displacement cannot use the undefined size.
	always_comb begin
		case (mode)
			eag_pkg::EAG_MODE_REG_INDIRECT,
			eag_pkg::EAG_MODE_POST_INC,
			eag_pkg::EAG_MODE_PRE_DEC,
			eag_pkg::EAG_MODE_DISP4,
			eag_pkg::EAG_MODE_INDEXED,
			eag_pkg::EAG_MODE_GBR_DISP: size_refused = (size == eag_pkg::EAG_SIZE_BAD);
			default:                    size_refused = 1'b0;
		endcase
	end

	// ****************************************************************
	// Address calculation.
	// ****************************************************************
	logic [31:0] next_ea;
	logic        next_mem;
	logic [31:0] next_operand;
	logic        next_operand_valid;
	logic        next_wb_en;
	logic [31:0] next_wb_value;
	logic        next_ctl_load;
	logic        next_ctl_from_mem;
	logic        next_error;

	// The sums are 32 bits wide on purpose so that carries out of bit 31 are dropped.
	always_comb begin
		next_ea            = eag_pkg::EAG_RST_WORD;
		next_mem           = 1'b0;
		next_operand       = eag_pkg::EAG_RST_WORD;
		next_operand_valid = 1'b0;
		next_wb_en         = 1'b0;
		next_wb_value      = eag_pkg::EAG_RST_WORD;
		next_ctl_load      = 1'b0;
		next_ctl_from_mem  = 1'b0;
		next_error         = 1'b0;
		case (mode)
			eag_pkg::EAG_MODE_REG_DIRECT: begin
				next_operand       = reg_value_in;
				next_operand_valid = 1'b1;
			end
			eag_pkg::EAG_MODE_REG_INDIRECT: begin
				next_ea  = reg_value_in;
				next_mem = 1'b1;
			end
			eag_pkg::EAG_MODE_POST_INC: begin
				next_ea       = reg_value_in;
				next_mem      = 1'b1;
				next_wb_en    = 1'b1;
				next_wb_value = inc_value;
			end
			eag_pkg::EAG_MODE_PRE_DEC: begin
				next_ea       = dec_value;
				next_mem      = 1'b1;
				next_wb_en    = 1'b1;
				next_wb_value = dec_value;
			end
			eag_pkg::EAG_MODE_DISP4: begin
				next_ea  = reg_value_in + eag_pkg::eag_scale(x_zext4, size);
				next_mem = 1'b1;
			end
			eag_pkg::EAG_MODE_INDEXED: begin
				next_ea  = reg_value_in + gr_zero_in;
				next_mem = 1'b1;
			end
			eag_pkg::EAG_MODE_GBR_DISP: begin
				next_ea  = global_base_register_in + eag_pkg::eag_scale(x_zext8, size);
				next_mem = 1'b1;
			end
			eag_pkg::EAG_MODE_PC_DISP8: begin
				next_ea  = pc_target(pc_in, x_sext8);
				next_mem = ~branch_in;
			end
			eag_pkg::EAG_MODE_PC_DISP12: begin
				next_ea  = pc_target(pc_in, x_sext12);
				next_mem = ~branch_in;
			end
			eag_pkg::EAG_MODE_PC_REG: begin
				next_ea  = pc_in + reg_value_in;
			end
			eag_pkg::EAG_MODE_IMM_ZERO: begin
				next_operand       = x_zext8;
				next_operand_valid = 1'b1;
			end
			eag_pkg::EAG_MODE_IMM_SIGN: begin
				next_operand       = x_sext8;
				next_operand_valid = 1'b1;
			end
			eag_pkg::EAG_MODE_TRAP: begin
				next_operand       = x_zext8 << eag_pkg::EAG_TRAP_SHIFT;
				next_operand_valid = 1'b1;
			end
			eag_pkg::EAG_MODE_CTL_REG: begin
				next_operand       = reg_value_in;
				next_operand_valid = 1'b1;
				next_ctl_load      = 1'b1;
			end
			eag_pkg::EAG_MODE_CTL_MEM: begin
				next_ea           = reg_value_in;
				next_mem          = 1'b1;
				next_wb_en        = 1'b1;
				next_wb_value     = inc_value;
				next_ctl_load     = 1'b1;
				next_ctl_from_mem = 1'b1;
			end
			default: begin
				next_error = 1'b1;
			end
		endcase
		// A scaled access with an undefined size is refused as a whole.
		if (size_refused) begin
			next_error = 1'b1;
		end
		if (next_error) begin
			next_mem           = 1'b0;
			next_wb_en         = 1'b0;
			next_ctl_load      = 1'b0;
			next_ctl_from_mem  = 1'b0;
			next_operand_valid = 1'b0;
		end
	end

	// ****************************************************************
	// Handshake pulses.
	// ****************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			done_out          <= 1'b0;
			error_out         <= 1'b0;
			mem_access_out    <= 1'b0;
			operand_valid_out <= 1'b0;
			wb_en_out         <= 1'b0;
			ctl_load_out      <= 1'b0;
			ctl_from_mem_out  <= 1'b0;
		end else begin
			done_out          <= req_valid_in;
			error_out         <= req_valid_in & next_error;
			mem_access_out    <= req_valid_in & next_mem;
			operand_valid_out <= req_valid_in & next_operand_valid;
			wb_en_out         <= req_valid_in & next_wb_en;
			ctl_load_out      <= req_valid_in & next_ctl_load;
			ctl_from_mem_out  <= req_valid_in & next_ctl_from_mem;
		end
	end

	// ****************************************************************
	// Result words.
	// ****************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			mode_out     <= eag_pkg::EAG_RST_MODE;
			ea_out       <= eag_pkg::EAG_RST_WORD;
			operand_out  <= eag_pkg::EAG_RST_WORD;
			wb_value_out <= eag_pkg::EAG_RST_WORD;
			wb_index_out <= eag_pkg::EAG_RST_NIB;
		end else if (req_valid_in) begin
			mode_out     <= mode_in;
			ea_out       <= next_ea;
			operand_out  <= next_operand;
			wb_value_out <= next_wb_value;
			wb_index_out <= next_wb_index;
		end
	end

	// ****************************************************************
	// Decoded fields.
	// ****************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			opcode_out    <= eag_pkg::EAG_RST_NIB;
			field_n_out   <= eag_pkg::EAG_RST_NIB;
			field_m_out   <= eag_pkg::EAG_RST_NIB;
			field_low_out <= eag_pkg::EAG_RST_NIB;
		end else if (req_valid_in) begin
			opcode_out    <= f_opcode;
			field_n_out   <= f_n;
			field_m_out   <= f_m;
			field_low_out <= f_low;
		end
	end

endmodule : eag_top
`default_nettype wire

// ---- test/eag_checker.sv ----
// Concurrent checks on the ports of the effective address generator.
`timescale 1ns/1ns
`default_nettype none

module eag_checker (
	// Clock and reset.
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	// Request.
	input wire logic        req_valid_in,
	input wire logic [15:0] instr_in,
	input wire logic [3:0]  mode_in,
	input wire logic [1:0]  size_in,
	input wire logic [31:0] reg_value_in,
	input wire logic [31:0] gr_zero_in,
	input wire logic [31:0] pc_in,
	// Result.
	input wire logic        done_out,
	input wire logic        error_out,
	input wire logic [31:0] ea_out,
	input wire logic        mem_access_out,
	input wire logic [31:0] operand_out,
	input wire logic        wb_en_out,
	input wire logic [31:0] wb_value_out,
	input wire logic        ctl_load_out,
	input wire logic        ctl_from_mem_out,
	input wire logic [3:0]  opcode_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_done_pulse: assert property (req_valid_in |=> done_out)
		else $error("done missing after request");
	a_done_cause: assert property (done_out |-> $past(req_valid_in) && !$past(rst_in))
		else $error("done without request");
	a_fields_split: assert property (req_valid_in |=> opcode_out == $past(instr_in[15:12]))
		else $error("opcode field wrong");
	a_postinc_long: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_POST_INC &&
		size_in == eag_pkg::EAG_SIZE_LONG |=> wb_en_out && ea_out == $past(reg_value_in) &&
		wb_value_out == $past(reg_value_in) + 32'h4)
		else $error("post increment wrong");
	a_predec_byte: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_PRE_DEC &&
		size_in == eag_pkg::EAG_SIZE_BYTE |=> wb_en_out && ea_out == wb_value_out &&
		wb_value_out == $past(reg_value_in) - 32'h1)
		else $error("pre decrement wrong");
	a_disp4_word: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_DISP4 &&
		size_in == eag_pkg::EAG_SIZE_WORD |=> mem_access_out &&
		ea_out == $past(reg_value_in) + {27'h0, $past(instr_in[3:0]), 1'b0})
		else $error("short displacement address wrong");
	a_indexed_sum: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_INDEXED && size_in != 2'h3
		|=> mem_access_out && ea_out == $past(reg_value_in) + $past(gr_zero_in))
		else $error("indexed address wrong");
	a_pc_short: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_PC_DISP8 |=> ea_out ==
		$past(pc_in) + {{23{$past(instr_in[7])}}, $past(instr_in[7:0]), 1'b0})
		else $error("short pc target wrong");
	a_pc_long: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_PC_DISP12 |=> ea_out ==
		$past(pc_in) + {{19{$past(instr_in[11])}}, $past(instr_in[11:0]), 1'b0})
		else $error("long pc target wrong");
	a_pc_reg: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_PC_REG
		|=> !mem_access_out && ea_out == $past(pc_in) + $past(reg_value_in))
		else $error("register pc target wrong");
	a_imm_sign: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_IMM_SIGN
		|=> operand_out == {{24{$past(instr_in[7])}}, $past(instr_in[7:0])})
		else $error("signed immediate wrong");
	a_trap_offset: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_TRAP
		|=> operand_out == {22'h0, $past(instr_in[7:0]), 2'h0})
		else $error("trap offset wrong");
	a_error_mode: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_UNUSED
		|=> error_out && !mem_access_out && !wb_en_out)
		else $error("unused mode not refused");
	a_ctl_mem: assert property (req_valid_in && mode_in == eag_pkg::EAG_MODE_CTL_MEM |=> ctl_load_out &&
		ctl_from_mem_out && wb_value_out == $past(reg_value_in) + 32'h4)
		else $error("control load from memory wrong");
	a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !done_out && !wb_en_out && !mem_access_out)
		else $error("outputs active after reset");

	c_postinc: cover property (req_valid_in && mode_in == eag_pkg::EAG_MODE_POST_INC);
	c_error: cover property (error_out);
	c_back: cover property (req_valid_in [*2]);
endmodule : eag_checker

bind eag_top eag_checker i_eag_checker (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
	.instr_in(instr_in), .mode_in(mode_in), .size_in(size_in), .reg_value_in(reg_value_in),
	.gr_zero_in(gr_zero_in), .pc_in(pc_in), .done_out(done_out), .error_out(error_out), .ea_out(ea_out),
	.mem_access_out(mem_access_out), .operand_out(operand_out), .wb_en_out(wb_en_out),
	.wb_value_out(wb_value_out), .ctl_load_out(ctl_load_out), .ctl_from_mem_out(ctl_from_mem_out),
	.opcode_out(opcode_out));

`default_nettype wire

// ---- test/eag_regfile_model.sv ----
// Register file model that feeds the generator and takes its write-back.
`timescale 1ns/1ns
`default_nettype none

module eag_regfile_model (
	// Clock and reset.
	input wire logic         sys_clk_in,
	input wire logic         rst_in,
	// Register selection.
	input wire logic  [15:0] instr_in,
	input wire logic         sel_src_in,
	// Write-back.
	input wire logic         wb_en_in,
	input wire logic  [3:0]  wb_index_in,
	input wire logic  [31:0] wb_value_in,
	// Register values.
	output logic      [31:0] reg_value_out,
	output logic      [31:0] gr_zero_out
);
	logic [31:0] regs [16];

	// Reset values straddle the wrap point so that steps cross it early.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < 16; i++) regs[i] <= 32'hffff_fff8 + 32'(i);
		end else if (wb_en_in) begin
			regs[wb_index_in] <= wb_value_in;
		end
	end

	assign reg_value_out = regs[sel_src_in ? instr_in[7:4] : instr_in[11:8]];
	assign gr_zero_out   = regs[0];
endmodule : eag_regfile_model

`default_nettype wire

// ---- test/test_effective_address_generator.sv ----
// Self-checking testbench of the effective address generator.
`timescale 1ns/1ns
`default_nettype none

module test_effective_address_generator;
	logic        sys_clk_in, rst_in, req_valid_in, sel_src_in, branch_in;
	logic [15:0] instr_in;
	logic [3:0]  mode_in, wb_index_out, mode_out, opcode_out, field_n_out, field_m_out, field_low_out;
	logic [1:0]  size_in;
	logic [31:0] reg_value_in, gr_zero_in, global_base_register_in, pc_in, ea_out, operand_out, wb_value_out;
	logic        done_out, error_out, mem_access_out, operand_valid_out, wb_en_out, ctl_load_out, ctl_from_mem_out;
	logic        s_valid, s_sel, s_br;
	logic [3:0]  s_mode;
	logic [1:0]  s_size;
	logic [15:0] s_instr;
	logic [31:0] s_reg, s_g0, s_gbr, s_pc;
	int          n_fail = 0;
	int          total_checks = 0;

	eag_top i_eag_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
		.instr_in(instr_in), .mode_in(mode_in), .size_in(size_in), .sel_src_in(sel_src_in),
		.branch_in(branch_in), .reg_value_in(reg_value_in), .gr_zero_in(gr_zero_in),
		.global_base_register_in(global_base_register_in), .pc_in(pc_in), .done_out(done_out),
		.error_out(error_out), .mode_out(mode_out), .ea_out(ea_out), .mem_access_out(mem_access_out),
		.operand_out(operand_out), .operand_valid_out(operand_valid_out), .wb_en_out(wb_en_out),
		.wb_index_out(wb_index_out), .wb_value_out(wb_value_out), .ctl_load_out(ctl_load_out),
		.ctl_from_mem_out(ctl_from_mem_out), .opcode_out(opcode_out), .field_n_out(field_n_out),
		.field_m_out(field_m_out), .field_low_out(field_low_out));

	eag_regfile_model i_eag_regfile_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .instr_in(instr_in),
		.sel_src_in(sel_src_in), .wb_en_in(wb_en_out), .wb_index_in(wb_index_out),
		.wb_value_in(wb_value_out), .reg_value_out(reg_value_in), .gr_zero_out(gr_zero_in));

	function automatic logic [31:0] stp(input logic [1:0] sz);
		return (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
	endfunction : stp

	function automatic logic [31:0] exp_ea();
		case (s_mode)
			4'h3:    return s_reg - stp(s_size);
			4'h4:    return s_reg + {28'h0, s_instr[3:0]} * stp(s_size);
			4'h5:    return s_reg + s_g0;
			4'h6:    return s_gbr + {24'h0, s_instr[7:0]} * stp(s_size);
			4'h7:    return s_pc + {{23{s_instr[7]}}, s_instr[7:0], 1'b0};
			4'h8:    return s_pc + {{19{s_instr[11]}}, s_instr[11:0], 1'b0};
			4'h9:    return s_pc + s_reg;
			default: return s_reg;
		endcase
	endfunction : exp_ea

	function automatic logic [31:0] exp_op();
		case (s_mode)
			4'ha:    return {24'h0, s_instr[7:0]};
			4'hb:    return {{24{s_instr[7]}}, s_instr[7:0]};
			4'hc:    return {22'h0, s_instr[7:0], 2'h0};
			default: return s_reg;
		endcase
	endfunction : exp_op

	task automatic cmpw(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmpw

	task automatic cmpb(input string nm, input logic exp, input logic got);
		cmpw(nm, {31'h0, exp}, {31'h0, got});
	endtask : cmpb

	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic drive(input logic v, input logic [3:0] m, input logic [1:0] s);
		req_valid_in            = v;
		mode_in                 = m;
		size_in                 = s;
		instr_in                = 16'($urandom);
		sel_src_in              = 1'($urandom);
		branch_in               = 1'($urandom);
		global_base_register_in = $urandom;
		pc_in                   = $urandom;
		@(posedge sys_clk_in);
		#1;
	endtask : drive

	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	// ****************************************************************
	// Snapshot of each taken request and comparison of its result.
	// ****************************************************************
	always @(posedge sys_clk_in) begin
		s_valid <= req_valid_in && !rst_in;
		{s_mode, s_size, s_instr, s_sel, s_br} <= {mode_in, size_in, instr_in, sel_src_in, branch_in};
		{s_reg, s_g0, s_gbr, s_pc} <= {reg_value_in, gr_zero_in, global_base_register_in, pc_in};
	end

	always @(posedge sys_clk_in) begin
		logic err;
		#1;
		err = s_mode == 4'hf || (s_size == 2'h3 && (s_mode inside {[4'h1:4'h6]}));
		cmpb("done", s_valid, done_out);
		if (s_valid) begin
			cmpb("error", err, error_out);
			cmpw("fields", {16'h0, s_instr}, {16'h0, opcode_out, field_n_out, field_m_out, field_low_out});
			cmpw("mode", {28'h0, s_mode}, {28'h0, mode_out});
			if (err) begin
				cmpb("mem", 1'b0, mem_access_out);
				cmpb("wb_en", 1'b0, wb_en_out);
				cmpb("ctl_load", 1'b0, ctl_load_out);
			end else begin
				if (s_mode inside {[4'h1:4'h9], 4'he}) cmpw("ea", exp_ea(), ea_out);
				cmpb("mem", s_mode inside {[4'h1:4'h6], 4'he} || (s_mode inside {4'h7, 4'h8} && !s_br), mem_access_out);
				cmpb("wb_en", s_mode inside {4'h2, 4'h3, 4'he}, wb_en_out);
				if (s_mode inside {4'h2, 4'h3, 4'he}) begin
					cmpw("wb_value", s_mode == 4'h3 ? exp_ea() : s_reg + (s_mode == 4'he ? 32'h4 : stp(s_size)), wb_value_out);
					cmpw("wb_index", {28'h0, s_sel ? s_instr[7:4] : s_instr[11:8]}, {28'h0, wb_index_out});
				end
				if (s_mode inside {4'h0, [4'ha:4'hd]}) begin
					cmpw("operand", exp_op(), operand_out);
				end
				cmpb("operand_valid", s_mode inside {4'h0, [4'ha:4'hd]}, operand_valid_out);
				cmpw("ctl", {30'h0, s_mode inside {4'hd, 4'he}, s_mode == 4'he}, {30'h0, ctl_load_out, ctl_from_mem_out});
			end
		end
	end

	// ****************************************************************
	// Main sequence and watchdog.
	// ****************************************************************
	initial begin
		rst_in = 1'b1;
		req_valid_in = 1'b0;
		{mode_in, size_in, instr_in, sel_src_in, branch_in, global_base_register_in, pc_in} = '0;
		void'($urandom(18));
		repeat (3) @(posedge sys_clk_in);
		#1;
		rst_in = 1'b0;
		for (int m = 0; m < 16; m++) begin
			for (int s = 0; s < 4; s++) begin
				if (!(s == 3 && m inside {0, [9:12]})) drive(1'b1, 4'(m), 2'(s));
			end
		end
		for (int n = 0; n < 300; n++) drive(($urandom % 4) != 0, 4'($urandom), 2'($urandom % 3));
		rst_in = 1'b1;
		drive(1'b1, 4'h2, 2'h2);
		drive(1'b1, 4'h3, 2'h0);
		rst_in = 1'b0;
		drive(1'b1, 4'h3, 2'h0);
		drive(1'b0, 4'h0, 2'h0);
		complete_run();
	end

	initial begin
		#(8 * 2000);
		n_fail++;
		complete_run();
	end
endmodule : test_effective_address_generator

`default_nettype wire
